// file: logic/cms_defines.svh
// register map, field positions, reset values and timing counts of the cell monitor sequencer
`ifndef CMS_DEFINES_SVH
`define CMS_DEFINES_SVH
`define CMS_A_CTRL     12'h000
`define CMS_A_MASK     12'h004
`define CMS_A_CMD      12'h008
`define CMS_A_STAT     12'h00C
`define CMS_A_FLAG     12'h010
`define CMS_A_LIM      12'h014
`define CMS_A_BAL      12'h018
`define CMS_A_DIAG     12'h01C
`define CMS_A_RES      12'h040
`define CMS_A_RES_END  12'h078
`define CMS_F_DUTY     2:0
`define CMS_F_TEN      3
`define CMS_F_LVL      4
`define CMS_F_CODE     3:0
`define CMS_F_CHK      8
`define CMS_F_UVL      11:0
`define CMS_F_OVL      27:16
`define CMS_DUTY_RST   3'h0
`define CMS_TEN_RST    1'b0
`define CMS_LVL_RST    1'b0
`define CMS_C_CELL     4'h1
`define CMS_C_OW       4'h2
`define CMS_C_CELL_K   4'h3
`define CMS_C_OW_K     4'h4
`define CMS_C_CLEAR    4'h5
`define CMS_C_TEST1    4'h6
`define CMS_C_TEST2    4'h7
`define CMS_C_DIAG     4'h8
`define CMS_ZERO_CODE  12'h200
`define CMS_CLR_CODE   12'hFFF
`define CMS_PAT1       12'h555
`define CMS_PAT2       12'hAAA
`define CMS_REF2_CHAN  4'hF
`define CMS_CLK_MHZ    25
`define CMS_CLR_US     1000
`define CMS_DIAG_US    16400
`define CMS_WIN_NS     5000
`define CMS_SQ_US      500
`define CMS_CLR_CYC    (`CMS_CLR_US * `CMS_CLK_MHZ)
`define CMS_DIAG_CYC   (`CMS_DIAG_US * `CMS_CLK_MHZ)
`define CMS_WIN_CYC    (`CMS_WIN_NS * `CMS_CLK_MHZ / 1000)
`define CMS_SQ_CYC     (`CMS_SQ_US * `CMS_CLK_MHZ)
`define CMS_PER_MS     {32'd2000, 32'd500, 32'd130, 32'd65, 32'd26, 32'd13}
`endif

// file: logic/cms_pkg.sv
// types shared by the cell monitor sequencer
package cms_pkg;
  typedef enum logic [4:0] {
    ST_STBY = 5'b00001,
    ST_IDLE = 5'b00010,
    ST_CONV = 5'b00100,
    ST_CLR  = 5'b01000,
    ST_DIAG = 5'b10000
  } cms_st_e;

  typedef enum logic [1:0] {
    KD_BLANK = 2'h0,
    KD_KEEP  = 2'h1,
    KD_TEST  = 2'h2,
    KD_SWEEP = 2'h3
  } cms_kind_e;

  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } cms_apb_req_s;

  typedef struct packed {
    cms_st_e          st;
    cms_kind_e        kind;
    logic [2:0]       duty;
    logic             ten;
    logic             lvl;
    logic [11:0]      mask;
    logic [11:0]      bal;
    logic [11:0]      uvl;
    logic [11:0]      ovl;
    logic [11:0]      uvf;
    logic [11:0]      ovf;
    logic [3:0]       chan;
    logic             pat;
    logic             wt;
    logic             req;
    logic [31:0]      cnt;
    logic [7:0]       win;
    logic [15:0]      sq;
    logic             tog;
    logic             poll;
    logic [11:0]      dis;
    logic [14:0][11:0] res;
    logic [11:0]      diag;
    logic             muxf;
    logic [31:0]      rdata;
    logic             err;
  } cms_state_s;
endpackage : cms_pkg

// file: logic/cms_sequencer.sv
// cell monitor sequencer: modes, limit sweeps, conversions, clear, self test, diagnostics
//
// Decided for this implementation: the APB interface to the registers and the address map.
`include "cms_defines.svh"

// Functional notes
// - power-up enters standby: no conversions, no comparisons.
// - duty field zero puts the block in standby and stops all activity; the code keeps the status toggle and dis_out balancing running.
// - standby during a conversion aborts it; results are left undefined.
// - duty 1 to 7 is measure mode; duty 1 idles until a start command.
// - duty 2 to 7 sweeps all cells against limits periodically and reports status.
// - status shows as 1 kHz toggling or as a static level.
// - a cell outside the limits sets its under or over flag.
// - start commands are taken any time in measure mode; busy/done is reported; the code drops them in the sweep window or while a conversion awaits data.
// - conversions update flags; periodic sweeps resume after completion.
// - a start inside a 5 us window of each sweep may be lost.
// - masked channels are excluded from measurement.
// - ten-cell select masks cells 11 and 12; defaults low.
// - results are 12-bit codes, 0x200 means zero volts, 1.5 mV steps.
// - blanking conversions switch off discharge of measured cell and neighbours.
// - periodic sweeps blank the checked cell and neighbours likewise.
// - keep-discharge conversions leave discharge switches as configured.
// - clear loads all results with 0xFFF within 1 ms.
// - a start with failed check byte is ignored, results unchanged.
// - self test fills all results with 0x555 or 0xAAA, full-measurement time.
// - diagnostic updates its registers each run and flags mux failure.
// - diagnostic converts the second reference and completes in 16.4 ms.
module cms_sequencer #(
  parameter logic [31:0]      CLR_CYC  = `CMS_CLR_CYC,
  parameter logic [31:0]      DIAG_CYC = `CMS_DIAG_CYC,
  parameter logic [15:0]      SQ_CYC   = 16'(`CMS_SQ_CYC),
  parameter logic [5:0][31:0] PER_MS   = `CMS_PER_MS,
  parameter logic [31:0]      PER_SCL  = 32'(`CMS_CLK_MHZ * 1000)
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // apb slave
  input  wire cms_pkg::cms_apb_req_s apb,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  // converter port
  output logic                       adc_req,
  output logic [3:0]                 adc_chan,
  input  wire logic                  adc_valid,
  input  wire logic [11:0]           adc_data,
  input  wire logic                  mux_ok,
  // pins toward the cells and host
  output logic [11:0]                dis_out,
  output logic                       poll_out
);
  import cms_pkg::*;

  cms_state_s  s;
  cms_state_s  n;
  logic        rs1;
  logic        rst_q;
  logic        acc;
  logic        wr;
  logic [11:0] emask;
  logic [3:0]  last;
  logic        viol;
  logic [31:0] per;

  // combined mask of unused channels
  function automatic logic [11:0] eff_mask(input logic [11:0] m, input logic t);
    eff_mask = m | (t ? 12'hC00 : 12'h000);
  endfunction : eff_mask

  // discharge switches that must be off while channel c converts
  function automatic logic [11:0] nbr(input logic [3:0] c);
    logic [13:0] w;
    w = 14'h0007 << c;
    nbr = w[12:1];
  endfunction : nbr

  // register read mux
  function automatic logic [31:0] rd(input cms_state_s q, input logic [11:0] a);
    logic [3:0] i;
    i = 4'(a[5:2] - 4'h0);
    rd = 32'h0000_0000;
    case (a)
      `CMS_A_CTRL: rd = {27'h0, q.lvl, q.ten, q.duty};
      `CMS_A_MASK: rd = {20'h0, q.mask};
      `CMS_A_STAT: rd = {18'h0, q.muxf, q.poll, q.chan, 5'(q.st), q.kind, q.wt};
      `CMS_A_FLAG: rd = {4'h0, q.ovf, 4'h0, q.uvf};
      `CMS_A_LIM:  rd = {4'h0, q.ovl, 4'h0, q.uvl};
      `CMS_A_BAL:  rd = {20'h0, q.bal};
      `CMS_A_DIAG: rd = {20'h0, q.diag};
      default: begin
        if (a >= `CMS_A_RES && a <= `CMS_A_RES_END) begin
          rd = {20'h0, q.res[i]};
        end
      end
    endcase
  endfunction : rd

  // address decode, shared by reads and writes
  function automatic logic hit(input logic [11:0] a);
    hit = (a[1:0] == 2'h0) && (a <= `CMS_A_DIAG ||
          (a >= `CMS_A_RES && a <= `CMS_A_RES_END));
  endfunction : hit

  // reset released through two flops so no part leaves reset a cycle early
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rs1   <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rs1   <= 1'b1;
      rst_q <= rs1;
    end
  end

  assign acc      = apb.psel && apb.penable;
  assign wr       = acc && apb.pwrite && hit(apb.paddr);
  assign emask    = eff_mask(s.mask, s.ten);
  assign last     = (s.kind == KD_TEST) ? 4'd14 : 4'd11;
  assign viol     = |{s.uvf, s.ovf};
  assign per      = PER_MS[3'(s.duty - 3'h2)] * PER_SCL;

  // next state
  always_comb begin
    n     = s;
    n.req = 1'b0;
    if (s.win != 8'h00) begin
      n.win = s.win - 8'h01;
    end
    case (s.st)
      ST_STBY: begin
        n.wt = 1'b0;
        if (s.duty != 3'h0) begin
          n.st  = ST_IDLE;
          n.cnt = 32'h0;
        end
      end
      ST_IDLE: begin
        // only duty 2..7 runs the periodic sweep; duty 1 waits
        if (s.duty >= 3'h2) begin
          n.cnt = s.cnt + 32'h1;
          if (s.cnt >= per - 32'h1) begin
            n.st   = ST_CONV;
            n.kind = KD_SWEEP;
            n.chan = 4'h0;
            n.cnt  = 32'h0;
            n.win  = 8'(`CMS_WIN_CYC);
          end
        end
      end
      ST_CONV: begin
        if (s.wt) begin
          if (adc_valid) begin
            n.wt   = 1'b0;
            n.chan = s.chan + 4'h1;
            if (s.kind == KD_TEST) begin
              n.res[s.chan] = s.pat ? `CMS_PAT2 : `CMS_PAT1;
            end else begin
              if (s.kind != KD_SWEEP) begin
                n.res[s.chan] = adc_data;
              end
              n.uvf[s.chan] = adc_data < s.uvl;
              n.ovf[s.chan] = adc_data > s.ovl;
            end
          end
        end else if (s.chan > last) begin
          n.st  = ST_IDLE;
          n.cnt = 32'h0;
        end else if (s.kind != KD_TEST && emask[s.chan]) begin
          n.chan = s.chan + 4'h1;
        end else begin
          n.req = 1'b1;
          n.wt  = 1'b1;
        end
      end
      ST_CLR: begin
        n.cnt = s.cnt + 32'h1;
        if (s.cnt >= CLR_CYC - 32'h1) begin
          n.st  = ST_IDLE;
          n.cnt = 32'h0;
        end
      end
      ST_DIAG: begin
        n.cnt = s.cnt + 32'h1;
        if (s.cnt == 32'h0) begin
          n.req = 1'b1;
          n.wt  = 1'b1;
        end
        if (s.wt && adc_valid) begin
          n.wt   = 1'b0;
          n.diag = adc_data;
        end
        if (s.cnt >= DIAG_CYC - 32'h1) begin
          n.muxf = !mux_ok;
          n.st   = ST_IDLE;
          n.cnt  = 32'h0;
          n.wt   = 1'b0;
        end
      end
      default: begin
        n.st = ST_STBY;
      end
    endcase

    // register writes; a command is taken only in measure mode with a good check byte, outside the sweep window, not awaiting data, else dropped
    if (wr) begin
      case (apb.paddr)
        `CMS_A_CTRL: begin
          n.duty = apb.pwdata[`CMS_F_DUTY];
          n.ten  = apb.pwdata[`CMS_F_TEN];
          n.lvl  = apb.pwdata[`CMS_F_LVL];
        end
        `CMS_A_MASK: n.mask = apb.pwdata[11:0];
        `CMS_A_LIM: begin
          n.uvl = apb.pwdata[`CMS_F_UVL];
          n.ovl = apb.pwdata[`CMS_F_OVL];
        end
        `CMS_A_BAL: n.bal = apb.pwdata[11:0];
        `CMS_A_CMD: begin
          // commands inside the sweep's early window are dropped
          if (apb.pwdata[`CMS_F_CHK] && s.duty != 3'h0 && s.win == 8'h00 &&
              !s.wt) begin
            n.chan = 4'h0;
            n.cnt  = 32'h0;
            // a sweep step about to request is dropped with the sweep, else it would hang
            n.req  = 1'b0;
            n.wt   = 1'b0;
            case (apb.pwdata[`CMS_F_CODE])
              `CMS_C_CELL, `CMS_C_OW: begin
                n.st   = ST_CONV;
                n.kind = KD_BLANK;
              end
              `CMS_C_CELL_K, `CMS_C_OW_K: begin
                n.st   = ST_CONV;
                n.kind = KD_KEEP;
              end
              `CMS_C_TEST1, `CMS_C_TEST2: begin
                n.st   = ST_CONV;
                n.kind = KD_TEST;
                n.pat  = apb.pwdata[`CMS_F_CODE] == `CMS_C_TEST2;
              end
              `CMS_C_CLEAR: begin
                n.st  = ST_CLR;
                n.res = {15{`CMS_CLR_CODE}};
              end
              `CMS_C_DIAG: n.st = ST_DIAG;
              default: n.st = s.st;
            endcase
          end
        end
        default: n.duty = n.duty;
      endcase
    end

    // standby overrides everything and drops any conversion in flight
    if (s.duty == 3'h0) begin
      n.st  = ST_STBY;
      n.wt  = 1'b0;
      n.req = 1'b0;
    end

    // discharge blanking around the converting cell
    n.dis = n.bal;
    if (n.st == ST_CONV && (n.kind == KD_BLANK || n.kind == KD_SWEEP)) begin
      n.dis = n.bal & ~nbr(n.chan);
    end

    // status output: busy, or a violation in duty 2..7, low; else toggle or high
    n.sq = s.sq + 16'h1;
    if (s.sq >= SQ_CYC - 16'h1) begin
      n.sq  = 16'h0;
      n.tog = !s.tog;
    end
    if ((n.st != ST_IDLE && n.st != ST_STBY && n.kind != KD_SWEEP) ||
        (s.duty >= 3'h2 && viol)) begin
      n.poll = 1'b0;
    end else begin
      n.poll = s.lvl ? 1'b1 : n.tog;
    end

    // read data captured in the setup cycle, ready in the access cycle
    if (apb.psel && !apb.penable) begin
      n.rdata = rd(s, apb.paddr);
      n.err   = !hit(apb.paddr);
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      s      <= '0;
      s.st   <= ST_STBY;
      s.kind <= KD_BLANK;
      s.duty <= `CMS_DUTY_RST;
      s.ten  <= `CMS_TEN_RST;
      s.lvl  <= `CMS_LVL_RST;
      s.res  <= {15{`CMS_ZERO_CODE}};
    end else begin
      s <= n;
    end
  end

  assign pready   = 1'b1;
  assign pslverr  = acc && s.err;
  assign prdata   = s.rdata;
  assign adc_req  = s.req;
  assign adc_chan = (s.st == ST_DIAG) ? `CMS_REF2_CHAN : s.chan;
  assign dis_out  = s.dis;
  assign poll_out = s.poll;

  // checks
  stby_entry_a: assert property (@(posedge clk) disable iff (!rst_q)
    s.duty == 3'h0 |=> s.st == ST_STBY) else $error("no standby");
  stby_abort_a: assert property (@(posedge clk) disable iff (!rst_q)
    s.duty == 3'h0 |=> !adc_req && !s.wt) else $error("no abort");
  duty_one_a: assert property (@(posedge clk) disable iff (!rst_q)
    s.duty == 3'h1 && s.st == ST_IDLE && !wr |=> s.st == ST_IDLE)
    else $error("duty one left idle");
  ov_flag_a: assert property (@(posedge clk) disable iff (!rst_q)
    s.st == ST_CONV && s.wt && adc_valid && s.kind != KD_TEST &&
    adc_data > s.ovl && s.duty != 3'h0 |=> s.ovf[$past(s.chan)])
    else $error("ov flag missing");
  ten_cell_a: assert property (@(posedge clk) disable iff (!rst_q)
    s.ten && s.kind != KD_TEST && adc_req && s.st == ST_CONV |-> adc_chan < 4'd10)
    else $error("masked cell converted");
  blank_sw_a: assert property (@(posedge clk) disable iff (!rst_q)
    adc_req && s.st == ST_CONV && s.kind != KD_KEEP && s.kind != KD_TEST
    |-> (dis_out & nbr(adc_chan)) == 12'h000) else $error("switch on");
  keep_sw_a: assert property (@(posedge clk) disable iff (!rst_q)
    s.st == ST_CONV && s.kind == KD_KEEP |-> dis_out == s.bal)
    else $error("keep changed switch");
  clear_res_a: assert property (@(posedge clk) disable iff (!rst_q)
    s.st != ST_CLR ##1 s.st == ST_CLR |-> s.res == {15{`CMS_CLR_CODE}})
    else $error("clear not 0xFFF");
  bad_check_a: assert property (@(posedge clk) disable iff (!rst_q)
    wr && apb.paddr == `CMS_A_CMD && !apb.pwdata[`CMS_F_CHK] && s.st == ST_IDLE &&
    s.duty == 3'h1 |=> s.st == ST_IDLE && $stable(s.res))
    else $error("bad check taken");
  test_pat_a: assert property (@(posedge clk) disable iff (!rst_q)
    s.st == ST_CONV && s.kind == KD_TEST && s.wt && adc_valid && s.duty != 3'h0
    |=> s.res[$past(s.chan)] == ($past(s.pat) ? `CMS_PAT2 : `CMS_PAT1))
    else $error("bad test pattern");

  // standby quiet, status pin, masking, stored results and command lengths
  stby_quiet_a: assert property (@(posedge clk) disable iff (!rst_q)
    s.st == ST_STBY |-> !adc_req) else $error("request in standby");
  poll_busy_a: assert property (@(posedge clk) disable iff (!rst_q)
    s.st == ST_CONV && s.kind != KD_SWEEP |-> !poll_out)
    else $error("busy not shown");
  poll_level_a: assert property (@(posedge clk) disable iff (!rst_q)
    s.lvl && s.duty == 3'h1 && s.st == ST_IDLE && !wr |=> poll_out)
    else $error("level not shown");
  mask_skip_a: assert property (@(posedge clk) disable iff (!rst_q)
    adc_req && s.st == ST_CONV && s.kind != KD_TEST |-> !emask[adc_chan])
    else $error("masked channel converted");
  uv_flag_a: assert property (@(posedge clk) disable iff (!rst_q)
    s.st == ST_CONV && s.wt && adc_valid && s.kind != KD_TEST &&
    adc_data < s.uvl && s.duty != 3'h0 |=> s.uvf[$past(s.chan)])
    else $error("uv flag missing");
  res_store_a: assert property (@(posedge clk) disable iff (!rst_q)
    s.st == ST_CONV && s.wt && adc_valid && s.kind != KD_TEST && s.kind != KD_SWEEP &&
    !wr |=> s.res[$past(s.chan)] == $past(adc_data))
    else $error("result not stored");
  clear_time_a: assert property (@(posedge clk) disable iff (!rst_q)
    s.st == ST_CLR && s.cnt >= CLR_CYC - 32'h1 && !wr |=> s.st == ST_IDLE)
    else $error("clear too long");
  diag_time_a: assert property (@(posedge clk) disable iff (!rst_q)
    s.st == ST_DIAG && s.cnt >= DIAG_CYC - 32'h1 && !wr
    |=> s.st == ST_IDLE && s.muxf == !$past(mux_ok))
    else $error("diagnostic end wrong");

  sweep_c: cover property (@(posedge clk) disable iff (!rst_q)
    s.st == ST_IDLE ##1 s.st == ST_CONV && s.kind == KD_SWEEP);
  conv_done_c: cover property (@(posedge clk) disable iff (!rst_q)
    s.st == ST_CONV && s.kind == KD_BLANK ##1 s.st == ST_IDLE);
  diag_done_c: cover property (@(posedge clk) disable iff (!rst_q)
    s.st == ST_DIAG ##1 s.st == ST_IDLE);
  test_done_c: cover property (@(posedge clk) disable iff (!rst_q)
    s.st == ST_CONV && s.kind == KD_TEST ##1 s.st == ST_IDLE);
  clear_done_c: cover property (@(posedge clk) disable iff (!rst_q)
    s.st == ST_CLR ##1 s.st == ST_IDLE);
endmodule : cms_sequencer

// file: verification/cms_adc_model.sv
// behavioural converter answering the sequencer's channel requests
module cms_adc_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // request side
  input  wire logic        adc_req,
  input  wire logic [3:0]  adc_chan,
  input  wire logic        slow,
  input  wire logic [11:0] base_code,
  // answer side
  output logic             adc_valid,
  output logic [11:0]      adc_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       busy;
  logic [3:0] chan_q;
  logic [3:0] left;
  // one request at a time; data flips when not valid so a stale code never matches
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy      <= 1'b0;
      chan_q    <= 4'h0;
      left      <= 4'h0;
      adc_valid <= 1'b0;
      adc_data  <= 12'h000;
    end else begin
      adc_valid <= 1'b0;
      adc_data  <= ~adc_data;
      if (adc_req && !busy) begin
        busy   <= 1'b1;
        chan_q <= adc_chan;
        left   <= slow ? 4'h6 : 4'h0;
      end else if (busy && left != 4'h0) begin
        left <= left - 4'h1;
      end else if (busy) begin
        busy      <= 1'b0;
        adc_valid <= 1'b1;
        adc_data  <= base_code + {4'h0, chan_q, 4'h0};
      end
    end
  end
endmodule : cms_adc_model

// file: verification/cell_monitor_sequencer_bench.sv
// self-checking bench of the cell monitor sequencer
`include "cms_defines.svh"
module cell_monitor_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  clk = 1'b0;
  logic                  rst_n = 1'b0;
  cms_pkg::cms_apb_req_s apb = '0;
  logic                  pready, pslverr, adc_req, adc_valid, poll_out, err;
  logic                  mux_ok = 1'b1;
  logic                  slow = 1'b0;
  logic                  ten, keep_on, pl, watch = 1'b0, busy_chk = 1'b0;
  logic [31:0]           prdata, rd, r;
  logic [31:0]           seed = 32'hFD55E74C;
  logic [3:0]            adc_chan, cur, code;
  logic [11:0]           adc_data, dis_out, msk, vis, uv, ov;
  logic [11:0]           bal = 12'h000;
  logic [11:0]           base = 12'h200;
  int                    num_errors = 0, total_checks = 0, cyc = 0, req_cnt = 0, s, t0;

  always #20 clk = ~clk;

  cms_sequencer #(.CLR_CYC(32'd20), .DIAG_CYC(32'd50), .SQ_CYC(16'd4), .PER_SCL(32'd1),
    .PER_MS({32'd800, 32'd700, 32'd600, 32'd500, 32'd400, 32'd300}))
  i_cms_sequencer (.clk(clk), .rst_n(rst_n), .apb(apb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .adc_req(adc_req), .adc_chan(adc_chan), .adc_valid(adc_valid),
    .adc_data(adc_data), .mux_ok(mux_ok), .dis_out(dis_out), .poll_out(poll_out));
  cms_adc_model i_cms_adc_model (.clk(clk), .rst_n(rst_n), .adc_req(adc_req),
    .adc_chan(adc_chan), .slow(slow), .base_code(base), .adc_valid(adc_valid),
    .adc_data(adc_data));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    if (num_errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up

  task automatic timeout_hit();
    num_errors++;
    wrap_up();
  endtask : timeout_hit

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // discharge bits of a measured cell and its two neighbours
  function automatic logic [11:0] blank(input logic [3:0] k);
    logic [13:0] m;
    m = 14'h7 << k;
    return m[12:1];
  endfunction : blank

  function automatic logic [31:0] exp_flag();
    logic [31:0] f;
    f = 32'h0;
    for (int c = 0; c < 12; c++) begin
      f[c] = (base + 12'(16 * c)) < uv;
      f[16 + c] = (base + 12'(16 * c)) > ov;
    end
    return f;
  endfunction : exp_flag

  // one apb transfer; answer taken at the edge where pready is seen high
  task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    apb.psel <= 1'b1;
    apb.penable <= 1'b0;
    apb.pwrite <= wr;
    apb.paddr <= a;
    apb.pwdata <= d;
    @(posedge clk);
    apb.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) timeout_hit();
    rd = prdata;
    err = pslverr;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
  endtask : apb_xfer

  task automatic cmd(input logic [3:0] c, input logic ok);
    apb_xfer(1'b1, `CMS_A_CMD, {23'h0, ok, 4'h0, c});
  endtask : cmd

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb_xfer(1'b0, `CMS_A_STAT, 32'h0);
      n++;
    end while (rd[7:3] !== 5'b00010 && n < 300);
    if (n >= 300) timeout_hit();
  endtask : wait_idle

  task automatic chk_res(input int n, input logic fixed, input logic [11:0] pat);
    for (int c = 0; c < n; c++) begin
      apb_xfer(1'b0, `CMS_A_RES + 12'(4 * c), 32'h0);
      check(rd, {20'h0, (fixed || !vis[c]) ? pat : base + 12'(16 * c)});
    end
  endtask : chk_res

  // blanking watch on each cell conversion answered while watch is set, busy level on commanded ones
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (adc_req) begin
      cur <= adc_chan;
      req_cnt <= req_cnt + 1;
    end
    if (adc_valid && watch && cur < 4'd12) begin
      check({20'h0, dis_out}, {20'h0, keep_on ? bal : bal & ~blank(cur)});
      if (busy_chk) check(32'(poll_out), 32'h0);
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    apb_xfer(1'b0, `CMS_A_CTRL, 32'h0);
    check(rd, 32'h0);
    apb_xfer(1'b0, `CMS_A_STAT, 32'h0);
    check(32'(rd[7:3]), 32'h1);
    apb_xfer(1'b0, 12'h020, 32'h0);
    check({err, rd[30:0]}, 32'h80000000);
    cmd(4'h1, 1'b1);
    repeat (30) @(posedge clk);
    check(req_cnt, 0);
    // commanded conversions with random masks, limits, balancing and converter speed
    for (int t = 0; t < 8; t++) begin
      r = rnd();
      base = 12'h100 + 12'(r[9:0]);
      msk = (t < 2) ? 12'h000 : r[21:10];
      ten = r[22];
      slow <= r[31];
      code = 4'(1 + t % 4);
      keep_on = code >= 4'h3;
      vis = ~(msk | (ten ? 12'hC00 : 12'h000));
      r = rnd();
      bal = r[11:0];
      uv = base + 12'h1 + 12'(r[18:12]);
      ov = base + 12'h80 + 12'(r[26:20]);
      apb_xfer(1'b1, `CMS_A_CTRL, {27'h0, 1'b1, ten, 3'h1});
      apb_xfer(1'b1, `CMS_A_MASK, {20'h0, msk});
      apb_xfer(1'b1, `CMS_A_BAL, {20'h0, bal});
      apb_xfer(1'b1, `CMS_A_LIM, {4'h0, ov, 4'h0, uv});
      t0 = cyc;
      cmd(`CMS_C_CLEAR, 1'b1);
      wait_idle();
      check(32'(cyc - t0 <= 32), 32'h1);
      if (t == 0) chk_res(15, 1'b1, 12'hFFF);
      watch = 1'b1;
      busy_chk = 1'b1;
      cmd(code, 1'b1);
      wait_idle();
      watch = 1'b0;
      busy_chk = 1'b0;
      chk_res(12, 1'b0, 12'hFFF);
      apb_xfer(1'b0, `CMS_A_FLAG, 32'h0);
      check(rd & {4'h0, vis, 4'h0, vis}, exp_flag() & {4'h0, vis, 4'h0, vis});
      s = req_cnt;
      cmd(code, 1'b0);
      repeat (20) @(posedge clk);
      check(req_cnt, s);
    end
    vis = 12'hFFF;
    for (int p = 0; p < 2; p++) begin
      cmd(4'(6 + p), 1'b1);
      wait_idle();
      chk_res(15, 1'b1, p ? 12'hAAA : 12'h555);
    end
    for (int p = 0; p < 2; p++) begin
      mux_ok <= p[0];
      cmd(`CMS_C_DIAG, 1'b1);
      t0 = cyc;
      wait_idle();
      check(32'(cyc - t0 >= 48 && cyc - t0 <= 62), 32'h1);
      apb_xfer(1'b0, `CMS_A_DIAG, 32'h0);
      check(rd, {20'h0, base + 12'hF0});
      apb_xfer(1'b0, `CMS_A_STAT, 32'h0);
      check(32'(rd[13]), 32'(!p[0]));
    end
    // idle in level mode shows a steady high, toggle mode flips every half period
    check(32'(poll_out), 32'h1);
    apb_xfer(1'b1, `CMS_A_CTRL, 32'h01);
    repeat (3) @(posedge clk);
    pl = poll_out;
    repeat (4) @(posedge clk);
    check(32'(poll_out), 32'(!pl));
    // periodic sweeps in level mode with cells outside the limits
    apb_xfer(1'b1, `CMS_A_MASK, 32'h0);
    apb_xfer(1'b1, `CMS_A_CTRL, 32'h12);
    keep_on = 1'b0;
    watch = 1'b1;
    repeat (700) @(posedge clk);
    watch = 1'b0;
    check(32'(poll_out), 32'h0);
    apb_xfer(1'b0, `CMS_A_FLAG, 32'h0);
    check(rd, exp_flag());
    // standby while a slow conversion is pending aborts it
    // a running sweep and its start window would swallow the command, so let both pass
    apb_xfer(1'b1, `CMS_A_CTRL, 32'h11);
    slow <= 1'b1;
    wait_idle();
    repeat (130) @(posedge clk);
    s = req_cnt;
    cmd(`CMS_C_CELL, 1'b1);
    repeat (10) @(posedge clk);
    check(32'(req_cnt > s), 32'h1);
    apb_xfer(1'b1, `CMS_A_CTRL, 32'h10);
    repeat (4) @(posedge clk);
    s = req_cnt;
    repeat (40) @(posedge clk);
    check(req_cnt, s);
    apb_xfer(1'b0, `CMS_A_STAT, 32'h0);
    check(32'(rd[7:3]), 32'h1);
    wrap_up();
  end
endmodule : cell_monitor_sequencer_bench
